//--- hw/sar_adc_conversion_control.sv
// What this block does
// - Converter held off during reset and while channel field is all ones.
// - With no new start after completion, the converter sits idle.
// - Wide modes approximate 12 bits; 8-bit mode approximates 9 bits.
// - 10-bit mode rounds to 10 bits; 8-bit mode rounds to 8, low only.
// - Result transfer sets the done flag; interrupt if enabled then.
// - Compare against compare values only when compare enable is set.
// - Clock select picks bus, bus/2, alternate or internal async; bus after reset.
// - Selected clock divided by 1, 2, 4 or 8 forms the conversion clock.
// - Selected async clock keeps running through wait and stop3.
// - Disabled pin: output hi-Z, input and pull-up off, port reads zero.
// - Bit n of pin disable register 3 controls channel 16 plus n.
// - With trigger enabled, a rising trigger edge starts a conversion.
// - Trigger edges during a conversion are ignored; continuous honours the first.
// - Software mode: any control 1 write starts, unless channel is all ones.
// - Continuous mode restarts after each transfer until aborted.
// - Outside 8-bit mode, high read without low read blocks transfer; flag clear, result lost.
// - After a block, convert again, except single compare with false condition.
// - Writes to control, config or compare registers, reset, stop abort conversion.
// - Abort keeps last result; reset returns results to reset values.
// - Async clock generator runs only once a conversion is started with it.
// - Low-power bit reduces power at a lower maximum conversion clock.
// - Clock select codes: 00 bus, 01 bus/2, 10 alternate, 11 async.
// - Mode codes: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
// - Divide codes: 00 by 1, 01 by 2, 10 by 4, 11 by 8.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "sar_adc_regs.svh"

module sar_adc_conversion_control
  import sar_adc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              compareIn,
  input  wire logic              altClkIn,
  input  wire logic              asyncOscIn,
  input  wire logic              hwTriggerIn,
  input  wire logic              stopEntry,
  input  wire logic [7:0]        portPinIn,
  output logic                   sampleEnable,
  output logic      [11:0]       dacCode,
  output logic                   converterEnable,
  output logic                   asyncOscEnable,
  output logic                   lowPowerMode,
  output logic                   conversionIrq,
  output logic      [7:0]        pinDisable,
  output logic      [7:0]        portReadData
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sc1_t        sc1;
  sc2_t        sc2;
  cfg_t        cfg;
  logic [7:0]  cvHigh;
  logic [7:0]  cvLow;
  logic        conversion_complete_flag;
  logic        highReadPending;
  logic [11:0] resultValue;
  conv_state_t state;
  conv_state_t next_state;
  pin_in_t     pinSync1;
  pin_in_t     pinSync2;
  pin_in_t     pinPrev;
  logic        busHalf;
  logic [2:0]  divCnt;
  logic [2:0]  divLast;
  logic        srcTick;
  logic        convTick;
  logic [4:0]  sampleCnt;
  logic [4:0]  sampleLast;
  logic [3:0]  bitIdx;
  logic        wrAcc;
  logic        rdAcc;
  logic        wrSc1;
  logic        wrAny;
  logic        chanOff;
  logic        trigRise;
  logic        swStart;
  logic        hwStart;
  logic        abortReq;
  logic        startNow;
  logic [12:0] sum10;
  logic [9:0]  sum8;
  logic [9:0]  r10;
  logic [7:0]  r8;
  logic [11:0] finalRes;
  logic [11:0] cmpValue;
  logic        cmpTrue;
  logic        cmpPass;
  logic        blocked;
  logic [11:0] xferData;
  logic        doTransfer;
  logic        restart;
  logic [7:0]  rdValue;
  logic        rdValid;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wrAcc = psel && penable && pwrite && pready;
  assign rdAcc = psel && penable && !pwrite && pready;
  assign wrSc1 = wrAcc && (paddr == `OFF_SC1);
  assign wrAny = wrAcc && (paddr == `OFF_SC1 || paddr == `OFF_SC2 || paddr == `OFF_CFG
                           || paddr == `OFF_CV_HIGH || paddr == `OFF_CV_LOW);

  always_comb begin
    rdValue = `BYTE_RESET;
    rdValid = 1'b1;
    case (paddr)
      `OFF_SC1:      rdValue = {conversion_complete_flag, sc1};
      `OFF_SC2:      rdValue = {state != ST_IDLE, sc2, 4'h0};
      `OFF_RES_HIGH: rdValue = {4'h0, resultValue[11:8]};
      `OFF_RES_LOW:  rdValue = resultValue[7:0];
      `OFF_CV_HIGH:  rdValue = cvHigh;
      `OFF_CV_LOW:   rdValue = cvLow;
      `OFF_CFG:      rdValue = cfg;
      `OFF_PIN_DIS3: rdValue = pinDisable;
      default:       rdValid = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rdValid;
      if (psel && !penable) begin
        prdata <= {24'h000000, rdValue};
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sc1        <= `SC1_RESET;
      sc2        <= `SC2_RESET;
      cfg        <= `CFG_RESET;
      cvHigh     <= `BYTE_RESET;
      cvLow      <= `BYTE_RESET;
      pinDisable <= `BYTE_RESET;
    end else if (wrAcc) begin
      case (paddr)
        `OFF_SC1:      sc1        <= pwdata[6:0];
        `OFF_SC2:      sc2        <= pwdata[6:4];
        `OFF_CFG:      cfg        <= pwdata[7:0];
        `OFF_CV_HIGH:  cvHigh     <= pwdata[7:0];
        `OFF_CV_LOW:   cvLow      <= pwdata[7:0];
        `OFF_PIN_DIS3: pinDisable <= pwdata[7:0];
        default:       ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and pin control
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pinSync1 <= '0;
      pinSync2 <= '0;
      pinPrev  <= '0;
    end else begin
      pinSync1 <= {compareIn, altClkIn, asyncOscIn, hwTriggerIn, portPinIn};
      pinSync2 <= pinSync1;
      pinPrev  <= pinSync2;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      portReadData <= `BYTE_RESET;
    end else begin
      portReadData <= pinSync2.port & ~pinDisable;
    end
  end

  assign trigRise = pinSync2.trig && !pinPrev.trig;

  // ----------------------------------------------------------------
  // Clock source select and divider
  // ----------------------------------------------------------------
  always_comb begin
    case (cfg.clkSel)
      CLK_BUS:      srcTick = 1'b1;
      CLK_BUS_DIV2: srcTick = busHalf;
      CLK_ALT:      srcTick = pinSync2.alt && !pinPrev.alt;
      CLK_ASYNC:    srcTick = pinSync2.osc && !pinPrev.osc && asyncOscEnable;
      default:      srcTick = 1'b0;
    endcase
  end

  assign divLast  = 3'((4'h1 << cfg.clkDiv) - 4'h1);
  assign convTick = srcTick && (divCnt == divLast) && (state != ST_IDLE);

  always_ff @(posedge clk) begin
    if (srst) begin
      busHalf <= 1'b0;
      divCnt  <= '0;
    end else begin
      busHalf <= !busHalf;
      if (state == ST_IDLE || startNow) begin
        divCnt <= '0;
      end else if (srcTick) begin
        divCnt <= (divCnt == divLast) ? 3'h0 : divCnt + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Start, abort and completion decisions
  // ----------------------------------------------------------------
  assign chanOff  = (sc1.channel == `CHAN_OFF);
  assign swStart  = wrSc1 && !sc2.hwTrigEnable && (pwdata[4:0] != `CHAN_OFF);
  assign hwStart  = sc2.hwTrigEnable && trigRise && (state == ST_IDLE) && !chanOff;
  assign abortReq = wrAny || (stopEntry && cfg.clkSel != CLK_ASYNC);

  assign sampleLast = cfg.longSample ? `SAMPLE_LONG_LAST : `SAMPLE_SHORT_LAST;

  always_comb begin
    sum10    = {1'b0, dacCode} + `RND10_ADD;
    sum8     = {1'b0, dacCode[8:0]} + `RND8_ADD;
    r10      = sum10[12] ? `SAT10 : sum10[11:2];
    r8       = sum8[9] ? `SAT8 : sum8[8:1];
    case (cfg.mode)
      MODE_8BIT:  finalRes = {4'h0, r8};
      MODE_10BIT: finalRes = {2'h0, r10};
      default:    finalRes = dacCode;
    endcase
    cmpValue = (cfg.mode == MODE_8BIT) ? {4'h0, cvLow} : {cvHigh[3:0], cvLow};
    cmpTrue  = sc2.cmpGreater ? (finalRes >= cmpValue) : (finalRes < cmpValue);
    cmpPass  = !sc2.cmpEnable || cmpTrue;
    xferData = sc2.cmpEnable ? finalRes - cmpValue : finalRes;
    blocked  = highReadPending && (cfg.mode != MODE_8BIT);
  end

  assign doTransfer = (state == ST_DONE) && cmpPass && !blocked;
  assign restart    = (state == ST_DONE)
                      && (sc1.continuous || (blocked && cmpPass));

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = ST_IDLE;
      ST_SAMPLE: if (convTick && sampleCnt == sampleLast) next_state = ST_APPROX;
      ST_APPROX: if (convTick && bitIdx == 4'h0) next_state = ST_DONE;
      ST_DONE:   next_state = restart ? ST_SAMPLE : ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
    if (swStart) begin
      next_state = ST_SAMPLE;
    end else if (abortReq || chanOff) begin
      next_state = ST_IDLE;
    end else if (hwStart) begin
      next_state = ST_SAMPLE;
    end
  end

  assign startNow = (next_state == ST_SAMPLE) && (state != ST_SAMPLE || swStart);

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sampleCnt <= '0;
      bitIdx    <= '0;
      dacCode   <= '0;
    end else if (startNow) begin
      sampleCnt <= '0;
      dacCode   <= '0;
    end else if (state == ST_SAMPLE && convTick) begin
      if (sampleCnt == sampleLast) begin
        bitIdx  <= (cfg.mode == MODE_8BIT) ? `MSB_NARROW : `MSB_WIDE;
        dacCode <= 12'h001 << ((cfg.mode == MODE_8BIT) ? `MSB_NARROW : `MSB_WIDE);
      end else begin
        sampleCnt <= sampleCnt + 5'h01;
      end
    end else if (state == ST_APPROX && convTick) begin
      if (!pinSync2.cmp) begin
        dacCode[bitIdx] <= 1'b0;
      end
      if (bitIdx != 4'h0) begin
        dacCode[bitIdx - 4'h1] <= 1'b1;
        bitIdx                 <= bitIdx - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result, flag and read blocking
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      resultValue <= `RESULT_RESET;
    end else if (doTransfer) begin
      resultValue <= xferData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_complete_flag <= 1'b0;
    end else if (doTransfer) begin
      conversion_complete_flag <= 1'b1;
    end else if (wrSc1 || (rdAcc && paddr == `OFF_RES_LOW)) begin
      conversion_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      highReadPending <= 1'b0;
    end else if (rdAcc && paddr == `OFF_RES_HIGH && cfg.mode != MODE_8BIT) begin
      highReadPending <= 1'b1;
    end else if (rdAcc && paddr == `OFF_RES_LOW) begin
      highReadPending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs and power control
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sampleEnable    <= 1'b0;
      converterEnable <= 1'b0;
      asyncOscEnable  <= 1'b0;
      lowPowerMode    <= 1'b0;
      conversionIrq   <= 1'b0;
    end else begin
      sampleEnable    <= (next_state == ST_SAMPLE);
      converterEnable <= !chanOff;
      asyncOscEnable  <= (next_state != ST_IDLE) && (cfg.clkSel == CLK_ASYNC);
      lowPowerMode    <= cfg.lowPower;
      conversionIrq   <= conversion_complete_flag && sc1.irqEnable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_swWrite;
    swStart;
  endsequence
  sequence s_sampling;
    state == ST_SAMPLE && sampleCnt == 5'h00;
  endsequence
  sequence s_xfer;
    doTransfer;
  endsequence

  property p_chan_off;
    chanOff && !swStart |=> state == ST_IDLE;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("converter active with channel off");

  property p_idle;
    state == ST_DONE && !restart && !swStart |=> state == ST_IDLE && !sampleEnable;
  endproperty
  a_idle: assert property (p_idle) else $error("converter not idle after completion");

  property p_msb;
    state == ST_SAMPLE && next_state == ST_APPROX |=>
      bitIdx == ((cfg.mode == MODE_8BIT) ? `MSB_NARROW : `MSB_WIDE);
  endproperty
  a_msb: assert property (p_msb) else $error("wrong approximation width");

  property p_round8;
    doTransfer && !sc2.cmpEnable && cfg.mode == MODE_8BIT |=>
      resultValue == {4'h0, $past(r8)};
  endproperty
  a_round8: assert property (p_round8) else $error("8-bit result not rounded");

  property p_done;
    s_xfer |=> conversion_complete_flag && resultValue == $past(xferData) ##1 (conversionIrq == sc1.irqEnable
      || !conversion_complete_flag);
  endproperty
  a_done: assert property (p_done) else $error("completion flag or irq wrong");

  property p_compare_off;
    state == ST_DONE && !sc2.cmpEnable && !blocked |-> doTransfer;
  endproperty
  a_compare_off: assert property (p_compare_off) else $error("transfer withheld");

  property p_sw_start;
    s_swWrite |=> s_sampling;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start missed");

  property p_trig_ignored;
    trigRise && state == ST_APPROX && !wrAny |=> state != ST_SAMPLE;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");

  property p_blocked;
    state == ST_DONE && blocked |=> $stable(resultValue) && !$rose(conversion_complete_flag);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked result transferred");

  property p_block_restart;
    state == ST_DONE && blocked && cmpPass && !abortReq && !chanOff |=> state == ST_SAMPLE;
  endproperty
  a_block_restart: assert property (p_block_restart) else $error("no restart after block");

  property p_abort;
    abortReq && !swStart && (state == ST_SAMPLE || state == ST_APPROX) |=>
      state == ST_IDLE && $stable(resultValue);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not honoured");

  property p_osc_off;
    state == ST_IDLE && next_state == ST_IDLE |=> !asyncOscEnable;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("async clock on while idle");

endmodule : sar_adc_conversion_control

//--- hw/sar_adc_regs.svh
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_SC1           8'h00
`define OFF_SC2           8'h04
`define OFF_RES_HIGH      8'h08
`define OFF_RES_LOW       8'h0C
`define OFF_CV_HIGH       8'h10
`define OFF_CV_LOW        8'h14
`define OFF_CFG           8'h18
`define OFF_PIN_DIS3      8'h1C

// ----------------------------------------------------------------
// Reset values and special codes
// ----------------------------------------------------------------
`define CHAN_OFF          5'h1F
`define SC1_RESET         7'h1F
`define SC2_RESET         3'h0
`define CFG_RESET         8'h00
`define BYTE_RESET        8'h00
`define RESULT_RESET      12'h000

// ----------------------------------------------------------------
// Conversion timing in conversion clock ticks, approximation MSBs and rounding constants
// ----------------------------------------------------------------
`define SAMPLE_SHORT_LAST 5'h03
`define SAMPLE_LONG_LAST  5'h17
`define MSB_WIDE          4'hB
`define MSB_NARROW        4'h8
`define RND10_ADD         13'h0002
`define RND8_ADD          10'h001
`define SAT10             10'h3FF
`define SAT8              8'hFF

`endif

//--- hw/sar_adc_pkg.sv
package sar_adc_pkg;

  typedef enum logic [1:0] {
    MODE_8BIT  = 2'h0,
    MODE_12BIT = 2'h1,
    MODE_10BIT = 2'h2,
    MODE_RSVD  = 2'h3
  } conv_mode_t;

  typedef enum logic [1:0] {
    CLK_BUS      = 2'h0,
    CLK_BUS_DIV2 = 2'h1,
    CLK_ALT      = 2'h2,
    CLK_ASYNC    = 2'h3
  } clk_src_t;

  typedef struct packed {
    logic       lowPower;
    logic [1:0] clkDiv;
    logic       longSample;
    conv_mode_t mode;
    clk_src_t   clkSel;
  } cfg_t;

  typedef struct packed {
    logic       irqEnable;
    logic       continuous;
    logic [4:0] channel;
  } sc1_t;

  typedef struct packed {
    logic hwTrigEnable;
    logic cmpEnable;
    logic cmpGreater;
  } sc2_t;

  typedef struct packed {
    logic       cmp;
    logic       alt;
    logic       osc;
    logic       trig;
    logic [7:0] port;
  } pin_in_t;

  typedef enum {ST_IDLE, ST_SAMPLE, ST_APPROX, ST_DONE} conv_state_t;

endpackage : sar_adc_pkg

//--- tb/tb_sar_adc_conversion_control.sv
`timescale 1ns/1ps
`include "sar_adc_regs.svh"

module tb_sar_adc_conversion_control
  import sar_adc_pkg::*;
;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        compareIn, hwTriggerIn, sampleEnable, converterEnable;
  logic        slowClk, stopEntry;
  logic        asyncOscEnable, lowPowerMode, conversionIrq;
  logic [7:0]  portPinIn, pinDisable, portReadData;
  logic [11:0] dacCode;
  int          numErrors, comparisons;

  sar_adc_conversion_control #(.ADDR_W(8)) DUT (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compareIn(compareIn), .altClkIn(slowClk), .asyncOscIn(slowClk),
    .hwTriggerIn(hwTriggerIn), .stopEntry(stopEntry), .portPinIn(portPinIn),
    .sampleEnable(sampleEnable), .dacCode(dacCode), .converterEnable(converterEnable),
    .asyncOscEnable(asyncOscEnable), .lowPowerMode(lowPowerMode),
    .conversionIrq(conversionIrq), .pinDisable(pinDisable), .portReadData(portReadData)
  );

  always #2.5 clk = ~clk;

  // Slow square wave standing in for the alternate and internal clocks
  always @(posedge clk) begin
    slowClk <= ~slowClk;
  end

  // ----------------------------------------------------------------
  // Bus access and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    if (n >= 20) check(32'h0, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFF_SC1, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 200);
  endtask : wait_flag

  task automatic convert(input logic [7:0] cfg, input logic [31:0] hi, input logic [31:0] lo);
    apb(1'b1, `OFF_CFG, {24'h0, cfg});
    apb(1'b1, `OFF_SC1, 32'h00);
    wait_flag();
    check(rd & 32'h80, 32'h80);
    apb(1'b0, `OFF_RES_HIGH, 32'h0);
    check(rd, hi);
    apb(1'b0, `OFF_RES_LOW, 32'h0);
    check(rd, lo);
  endtask : convert

  task automatic close_out();
    if (numErrors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    #400000;
    numErrors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  addrs [6];
    logic [31:0] resets[6];
    addrs  = '{`OFF_SC1, `OFF_SC2, `OFF_CFG, `OFF_PIN_DIS3, `OFF_RES_HIGH, `OFF_RES_LOW};
    resets = '{32'h1F, 32'h00, 32'h00, 32'h00, 32'h00, 32'h00};
    clk = 1'b0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; compareIn = 1'b1; hwTriggerIn = 1'b0;
    portPinIn = 8'hFF; numErrors = 0; comparisons = 0;
    slowClk = 1'b0;
    stopEntry = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    check({31'h0, converterEnable}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, addrs[i], 32'h0);
      check(rd, resets[i]);
    end
    // Pin disable and masked port reads
    apb(1'b1, `OFF_PIN_DIS3, 32'hA5);
    repeat (4) @(posedge clk);
    check({24'h0, pinDisable}, 32'hA5);
    check({24'h0, portReadData}, 32'h5A);
    apb(1'b0, `OFF_PIN_DIS3, 32'h0);
    check(rd, 32'hA5);
    apb(1'b0, 8'hF0, 32'h0);
    check({31'h0, pslverr}, 32'h1);
    check(rd, 32'h0);
    // Every mode with a full-scale input, divider settings in turn, then a zero input
    convert(8'h04, 32'h0F, 32'hFF);
    check({20'h0, dacCode}, 32'hFFF);
    convert(8'h08, 32'h03, 32'hFF);
    convert(8'h20, 32'h00, 32'hFF);
    check({20'h0, dacCode}, 32'h1FF);
    convert(8'h44, 32'h0F, 32'hFF);
    convert(8'h05, 32'h0F, 32'hFF);
    convert(8'h06, 32'h0F, 32'hFF);
    check({31'h0, lowPowerMode}, 32'h0);
    convert(8'hE4, 32'h0F, 32'hFF);
    check({31'h0, lowPowerMode}, 32'h1);
    compareIn <= 1'b0;
    convert(8'h04, 32'h00, 32'h00);
    // Completion interrupt
    apb(1'b1, `OFF_SC1, 32'h40);
    wait_flag();
    repeat (2) @(posedge clk);
    check({31'h0, conversionIrq}, 32'h1);
    apb(1'b0, `OFF_RES_LOW, 32'h0);
    repeat (3) @(posedge clk);
    check({31'h0, conversionIrq}, 32'h0);
    // Abort by a config write keeps the last result
    compareIn <= 1'b1;
    apb(1'b1, `OFF_SC1, 32'h00);
    apb(1'b1, `OFF_CFG, 32'h04);
    repeat (150) @(posedge clk);
    apb(1'b0, `OFF_SC1, 32'h0);
    check(rd & 32'h80, 32'h00);
    apb(1'b0, `OFF_RES_LOW, 32'h0);
    check(rd, 32'h00);
    // Blocked transfer until the low byte is read
    apb(1'b0, `OFF_RES_HIGH, 32'h0);
    apb(1'b1, `OFF_SC1, 32'h00);
    repeat (200) @(posedge clk);
    apb(1'b0, `OFF_SC1, 32'h0);
    check(rd & 32'h80, 32'h00);
    apb(1'b0, `OFF_RES_LOW, 32'h0);
    check(rd, 32'h00);
    wait_flag();
    check(rd & 32'h80, 32'h80);
    apb(1'b0, `OFF_RES_LOW, 32'h0);
    check(rd, 32'hFF);
    // Continuous conversions restart after each transfer
    apb(1'b1, `OFF_SC1, 32'h20);
    wait_flag();
    apb(1'b0, `OFF_RES_LOW, 32'h0);
    wait_flag();
    check(rd & 32'h80, 32'h80);
    apb(1'b1, `OFF_SC1, 32'h1F);
    repeat (2) @(posedge clk);
    check({31'h0, converterEnable}, 32'h0);
    repeat (150) @(posedge clk);
    check({31'h0, sampleEnable}, 32'h0);
    // Stop entry aborts unless the internal clock is selected
    apb(1'b1, `OFF_SC1, 32'h00);
    stopEntry <= 1'b1;
    @(posedge clk);
    stopEntry <= 1'b0;
    repeat (150) @(posedge clk);
    apb(1'b0, `OFF_SC1, 32'h0);
    check(rd & 32'h80, 32'h00);
    apb(1'b1, `OFF_CFG, 32'h07);
    apb(1'b1, `OFF_SC1, 32'h00);
    stopEntry <= 1'b1;
    @(posedge clk);
    check({31'h0, asyncOscEnable}, 32'h1);
    stopEntry <= 1'b0;
    wait_flag();
    check(rd & 32'h80, 32'h80);
    check({31'h0, asyncOscEnable}, 32'h0);
    // Compare function, true then false
    apb(1'b1, `OFF_CV_HIGH, 32'h01);
    apb(1'b1, `OFF_CV_LOW, 32'h00);
    apb(1'b1, `OFF_SC2, 32'h30);
    convert(8'h04, 32'h0E, 32'hFF);
    apb(1'b1, `OFF_SC2, 32'h20);
    apb(1'b1, `OFF_SC1, 32'h00);
    repeat (150) @(posedge clk);
    apb(1'b0, `OFF_SC1, 32'h0);
    check(rd & 32'h80, 32'h00);
    // Hardware trigger
    apb(1'b1, `OFF_SC2, 32'h40);
    apb(1'b1, `OFF_SC1, 32'h00);
    repeat (150) @(posedge clk);
    apb(1'b0, `OFF_SC1, 32'h0);
    check(rd & 32'h80, 32'h00);
    hwTriggerIn <= 1'b1;
    repeat (4) @(posedge clk);
    hwTriggerIn <= 1'b0;
    wait_flag();
    check(rd & 32'h80, 32'h80);
    apb(1'b0, `OFF_SC2, 32'h0);
    check(rd & 32'hC0, 32'h40);
    // Reset while idle returns the results to their reset values
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, `OFF_RES_LOW, 32'h0);
    check(rd, 32'h00);
    close_out();
  end
endmodule : tb_sar_adc_conversion_control
